// file: src/pin_change_pkg.sv
package pin_change_pkg;

  // ==========================================================================
  // Register offsets (printed offsets are not multiples of four: word index).
  // ==========================================================================
  localparam logic [11:0] A_FLAG_IDX = 12'hF05;
  localparam logic [11:0] A_FALL_IDX = 12'hF06;
  localparam logic [11:0] A_RISE_IDX = 12'hF07;
  localparam logic [11:0] B_FLAG_IDX = 12'hF0D;
  localparam logic [11:0] B_FALL_IDX = 12'hF0E;
  localparam logic [11:0] B_RISE_IDX = 12'hF0F;
  localparam logic [11:0] C_FLAG_IDX = 12'hF15;
  localparam logic [11:0] C_FALL_IDX = 12'hF16;
  localparam logic [11:0] C_RISE_IDX = 12'hF17;
  localparam logic [11:0] E_FLAG_IDX = 12'hF22;
  localparam logic [11:0] E_FALL_IDX = 12'hF23;
  localparam logic [11:0] E_RISE_IDX = 12'hF24;
  localparam logic [11:0] IRQ_STAT_IDX = 12'hF30;
  localparam logic [11:0] IRQ_CLR_IDX = 12'hF31;
  localparam logic [11:0] IRQ_EN_IDX = 12'hF32;

  // ==========================================================================
  // Field positions and reset values.
  // ==========================================================================
  localparam int E_PIN_BIT = 3;
  localparam logic [7:0] E_PIN_MASK = 8'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CHANGE_IRQ_BIT = 0;

endpackage

// file: src/pin_change_detect.sv
// Contract
// - Falling enable set: high-to-low transition on the pin is a change event.
// - Rising enable set: low-to-high transition on the pin is a change event.
// - Enabled edge sets the pin's change bit and the shared change flag.
// - Enable bit clear: no change recorded for that pin and direction.
// - Ports A, B, C have eight rise and eight fall enables, bits 0-7.
// - Port E has rise and fall enables only at bit 3.
// - Master-clear or low-voltage-program option set disables port E bit 3 detection.
// - Change bits set by hardware, held until software writes them to zero.
// - Change bit set by rising edge with rise enable, falling with fall enable.
`timescale 1ns/1ps
`default_nettype none

module pin_change_detect (
  // Clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [15:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pin levels and configuration options.
  input wire logic [7:0] port_a_i,
  input wire logic [7:0] port_b_i,
  input wire logic [7:0] port_c_i,
  input wire logic port_e_bit3_pin_i,
  input wire logic master_clear_pin_enable_i,
  input wire logic low_voltage_program_enable_i,
  // Interrupt.
  output logic irq_o
);

  // ==========================================================================
  // State.
  // ==========================================================================
  logic [7:0] port_a_rise_enable, port_a_fall_enable, port_a_change_status;
  logic [7:0] port_b_rise_enable, port_b_fall_enable, port_b_change_status;
  logic [7:0] port_c_rise_enable, port_c_fall_enable, port_c_change_status;
  logic [7:0] port_e_rise_enable, port_e_fall_enable, port_e_change_status;
  logic [7:0] prev_a, prev_b, prev_c, prev_e;
  logic change_flag, change_irq_en;
  logic primed;

  // Detects enabled edges on one port.
  function automatic logic [7:0] edges(input logic [7:0] now, input logic [7:0] old,
                                       input logic [7:0] rise, input logic [7:0] fall);
    edges = (now & ~old & rise) | (~now & old & fall);
  endfunction

  // Match of a byte address against a word index, for address decode.
  function automatic logic hit(input logic [15:0] addr, input logic [11:0] idx);
    hit = (addr[15:2] == {2'h0, idx}) && (addr[1:0] == 2'h0);
  endfunction

  // ==========================================================================
  // Decode and edge detection.
  // ==========================================================================
  wire logic e_pin_disabled = master_clear_pin_enable_i | low_voltage_program_enable_i;
  wire logic [7:0] now_e = {4'h0, port_e_bit3_pin_i, 3'h0};
  wire logic [7:0] e_gate = e_pin_disabled ? 8'h00 : pin_change_pkg::E_PIN_MASK;
  wire logic [7:0] ev_a = primed ? edges(port_a_i, prev_a, port_a_rise_enable,
                                         port_a_fall_enable) : 8'h00;
  wire logic [7:0] ev_b = primed ? edges(port_b_i, prev_b, port_b_rise_enable,
                                         port_b_fall_enable) : 8'h00;
  wire logic [7:0] ev_c = primed ? edges(port_c_i, prev_c, port_c_rise_enable,
                                         port_c_fall_enable) : 8'h00;
  wire logic [7:0] ev_e = primed ? (edges(now_e, prev_e, port_e_rise_enable,
                                          port_e_fall_enable) & e_gate) : 8'h00;
  wire logic any_event = |{ev_a, ev_b, ev_c, ev_e};

  wire logic access = psel_i & penable_i;
  wire logic wr = access & pwrite_i & pstrb_i[0];
  wire logic w_a_rise = wr & hit(paddr_i, pin_change_pkg::A_RISE_IDX);
  wire logic w_a_fall = wr & hit(paddr_i, pin_change_pkg::A_FALL_IDX);
  wire logic w_a_flag = wr & hit(paddr_i, pin_change_pkg::A_FLAG_IDX);
  wire logic w_b_rise = wr & hit(paddr_i, pin_change_pkg::B_RISE_IDX);
  wire logic w_b_fall = wr & hit(paddr_i, pin_change_pkg::B_FALL_IDX);
  wire logic w_b_flag = wr & hit(paddr_i, pin_change_pkg::B_FLAG_IDX);
  wire logic w_c_rise = wr & hit(paddr_i, pin_change_pkg::C_RISE_IDX);
  wire logic w_c_fall = wr & hit(paddr_i, pin_change_pkg::C_FALL_IDX);
  wire logic w_c_flag = wr & hit(paddr_i, pin_change_pkg::C_FLAG_IDX);
  wire logic w_e_rise = wr & hit(paddr_i, pin_change_pkg::E_RISE_IDX);
  wire logic w_e_fall = wr & hit(paddr_i, pin_change_pkg::E_FALL_IDX);
  wire logic w_e_flag = wr & hit(paddr_i, pin_change_pkg::E_FLAG_IDX);
  wire logic w_clr = wr & hit(paddr_i, pin_change_pkg::IRQ_CLR_IDX);
  wire logic w_en = wr & hit(paddr_i, pin_change_pkg::IRQ_EN_IDX);
  wire logic [7:0] wd = pwdata_i[7:0];

  // Writing a zero to a change bit clears it; an edge in the same cycle wins.
  wire logic [7:0] next_a_status = (w_a_flag ? (port_a_change_status & wd)
                                             : port_a_change_status) | ev_a;
  wire logic [7:0] next_b_status = (w_b_flag ? (port_b_change_status & wd)
                                             : port_b_change_status) | ev_b;
  wire logic [7:0] next_c_status = (w_c_flag ? (port_c_change_status & wd)
                                             : port_c_change_status) | ev_c;
  wire logic [7:0] next_e_status = ((w_e_flag ? (port_e_change_status & wd)
                                              : port_e_change_status)
                                    & pin_change_pkg::E_PIN_MASK) | ev_e;
  wire logic next_change_flag = (change_flag & ~(w_clr & wd[pin_change_pkg::CHANGE_IRQ_BIT]))
                                | any_event;

  // Read multiplexer; unmapped addresses read zero with an error.
  wire logic [7:0] rd_byte =
    hit(paddr_i, pin_change_pkg::A_FLAG_IDX) ? port_a_change_status :
    hit(paddr_i, pin_change_pkg::A_FALL_IDX) ? port_a_fall_enable :
    hit(paddr_i, pin_change_pkg::A_RISE_IDX) ? port_a_rise_enable :
    hit(paddr_i, pin_change_pkg::B_FLAG_IDX) ? port_b_change_status :
    hit(paddr_i, pin_change_pkg::B_FALL_IDX) ? port_b_fall_enable :
    hit(paddr_i, pin_change_pkg::B_RISE_IDX) ? port_b_rise_enable :
    hit(paddr_i, pin_change_pkg::C_FLAG_IDX) ? port_c_change_status :
    hit(paddr_i, pin_change_pkg::C_FALL_IDX) ? port_c_fall_enable :
    hit(paddr_i, pin_change_pkg::C_RISE_IDX) ? port_c_rise_enable :
    hit(paddr_i, pin_change_pkg::E_FLAG_IDX) ? port_e_change_status :
    hit(paddr_i, pin_change_pkg::E_FALL_IDX) ? port_e_fall_enable :
    hit(paddr_i, pin_change_pkg::E_RISE_IDX) ? port_e_rise_enable :
    hit(paddr_i, pin_change_pkg::IRQ_STAT_IDX) ? {7'h00, change_flag} :
    hit(paddr_i, pin_change_pkg::IRQ_EN_IDX) ? {7'h00, change_irq_en} : 8'h00;
  wire logic mapped = (paddr_i[15:2] >= {2'h0, pin_change_pkg::A_FLAG_IDX})
    && (hit(paddr_i, pin_change_pkg::A_FLAG_IDX) || hit(paddr_i, pin_change_pkg::A_FALL_IDX)
    || hit(paddr_i, pin_change_pkg::A_RISE_IDX) || hit(paddr_i, pin_change_pkg::B_FLAG_IDX)
    || hit(paddr_i, pin_change_pkg::B_FALL_IDX) || hit(paddr_i, pin_change_pkg::B_RISE_IDX)
    || hit(paddr_i, pin_change_pkg::C_FLAG_IDX) || hit(paddr_i, pin_change_pkg::C_FALL_IDX)
    || hit(paddr_i, pin_change_pkg::C_RISE_IDX) || hit(paddr_i, pin_change_pkg::E_FLAG_IDX)
    || hit(paddr_i, pin_change_pkg::E_FALL_IDX) || hit(paddr_i, pin_change_pkg::E_RISE_IDX)
    || hit(paddr_i, pin_change_pkg::IRQ_STAT_IDX) || hit(paddr_i, pin_change_pkg::IRQ_CLR_IDX)
    || hit(paddr_i, pin_change_pkg::IRQ_EN_IDX));
  wire logic next_ready = psel_i & ~penable_i;

  // ==========================================================================
  // Enable registers.
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      port_a_rise_enable <= pin_change_pkg::REG_RESET;
      port_a_fall_enable <= pin_change_pkg::REG_RESET;
      port_b_rise_enable <= pin_change_pkg::REG_RESET;
      port_b_fall_enable <= pin_change_pkg::REG_RESET;
      port_c_rise_enable <= pin_change_pkg::REG_RESET;
      port_c_fall_enable <= pin_change_pkg::REG_RESET;
      port_e_rise_enable <= pin_change_pkg::REG_RESET;
      port_e_fall_enable <= pin_change_pkg::REG_RESET;
      change_irq_en <= 1'b0;
    end else begin
      if (w_a_rise) port_a_rise_enable <= wd;
      if (w_a_fall) port_a_fall_enable <= wd;
      if (w_b_rise) port_b_rise_enable <= wd;
      if (w_b_fall) port_b_fall_enable <= wd;
      if (w_c_rise) port_c_rise_enable <= wd;
      if (w_c_fall) port_c_fall_enable <= wd;
      if (w_e_rise) port_e_rise_enable <= wd & pin_change_pkg::E_PIN_MASK;
      if (w_e_fall) port_e_fall_enable <= wd & pin_change_pkg::E_PIN_MASK;
      if (w_en) change_irq_en <= wd[pin_change_pkg::CHANGE_IRQ_BIT];
    end
  end

  // ==========================================================================
  // Pin history, change bits and interrupt.
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prev_a <= 8'h00;
      prev_b <= 8'h00;
      prev_c <= 8'h00;
      prev_e <= 8'h00;
      primed <= 1'b0;
      port_a_change_status <= pin_change_pkg::REG_RESET;
      port_b_change_status <= pin_change_pkg::REG_RESET;
      port_c_change_status <= pin_change_pkg::REG_RESET;
      port_e_change_status <= pin_change_pkg::REG_RESET;
      change_flag <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      prev_a <= port_a_i;
      prev_b <= port_b_i;
      prev_c <= port_c_i;
      prev_e <= now_e;
      primed <= 1'b1;
      port_a_change_status <= next_a_status;
      port_b_change_status <= next_b_status;
      port_c_change_status <= next_c_status;
      port_e_change_status <= next_e_status;
      change_flag <= next_change_flag;
      irq_o <= next_change_flag & change_irq_en;
    end
  end

  // ==========================================================================
  // APB answer: no wait state, data and error registered.
  // ==========================================================================
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= next_ready;
      prdata_o <= next_ready ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr_o <= next_ready & ~mapped;
    end
  end

endmodule

`default_nettype wire

// file: test/pin_change_detect_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checks of the pin change block.
module pin_change_detect_asserts (
  // Clock, reset and APB.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pins and interrupt.
  input wire logic [7:0] port_a_i,
  input wire logic [7:0] port_b_i,
  input wire logic [7:0] port_c_i,
  input wire logic port_e_bit3_pin_i,
  input wire logic irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // All pin levels together, and a committed write access.
  wire [24:0] pins = {port_a_i, port_b_i, port_c_i, port_e_bit3_pin_i};
  wire wr_acc = psel_i && penable_i && pwrite_i;
  // Setup phase of a transfer.
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  ready_after_setup_a: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h00000000)
    else $error("read data outside access");
  rdata_byte_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
    else $error("read data above one byte");
  irq_after_reset_a: assert property ($rose(rst_n_i) |-> !irq_o ##1 !irq_o)
    else $error("interrupt right after reset");
  irq_rise_cause_a: assert property ($rose(irq_o) |-> $past(pins) != $past(pins, 2)
    || $past(pins, 2) != $past(pins, 3) || $past(wr_acc) || $past(wr_acc, 2))
    else $error("interrupt without pin change");
  irq_hold_a: assert property ($fell(irq_o) |-> $past(wr_acc) || $past(wr_acc, 2)
    || !$past(rst_n_i)) else $error("interrupt dropped without software");
endmodule
bind pin_change_detect pin_change_detect_asserts chk (.ref_clk_i, .rst_n_i, .psel_i,
  .penable_i, .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .port_a_i, .port_b_i,
  .port_c_i, .port_e_bit3_pin_i, .irq_o);
`default_nettype wire

// file: test/pin_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Outside world driving the port pins.
module pin_source (
  // Clock and requested levels.
  input wire logic ref_clk_i,
  input wire logic [24:0] level_i,
  // Pin levels seen by the block.
  output logic [24:0] pins_o
);
  // Pins follow the request one edge late, like a slow external driver.
  initial pins_o = 25'h0000000;
  always @(posedge ref_clk_i) pins_o <= level_i;
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the pin change block.
module tb;
  logic ref_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [15:0] paddr_i = 16'h0000;
  logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
  logic [3:0] pstrb_i = 4'hF;
  logic mclr = 1'b0, low_voltage_program_enable = 1'b0, pready_o, pslverr_o, irq_o, err, ien, any;
  logic [24:0] level = 25'h0000000, pins;
  logic [7:0] rise [4], fall [4], flg [4], prev [4], cur [4], m;
  logic [11:0] base [4] = '{pin_change_pkg::A_FLAG_IDX, pin_change_pkg::B_FLAG_IDX,
    pin_change_pkg::C_FLAG_IDX, pin_change_pkg::E_FLAG_IDX};
  int seed = 23, n_errors = 0, n_compared = 0;
  initial forever #50 ref_clk_i = ~ref_clk_i;
  pin_source far (.ref_clk_i, .level_i(level), .pins_o(pins));
  pin_change_detect dut (.ref_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .port_a_i(pins[24:17]),
    .port_b_i(pins[16:9]), .port_c_i(pins[8:1]), .port_e_bit3_pin_i(pins[0]),
    .master_clear_pin_enable_i(mclr), .low_voltage_program_enable_i(low_voltage_program_enable), .irq_o);
  // One APB transfer; ready, data and error are taken at the rising edge where ready is high.
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    {psel_i, penable_i, pwrite_i} <= {1'b1, 1'b0, w};
    paddr_i <= {2'b00, idx, 2'b00};
    pwdata_i <= {24'h000000, wd};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n == 20) n_errors++;
    {rd, err} = {prdata_o, pslverr_o};
    {psel_i, penable_i} <= 2'b00;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Edges that must be recorded for old and new levels and both enables.
  function automatic logic [7:0] edges(input logic [7:0] o, n, r, f);
    return (~o & n & r) | (o & ~n & f);
  endfunction
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard, far beyond the expected run length.
  initial begin
    #(100 * 40000);
    n_errors++;
    tally_and_finish();
  end
  // Main sequence: reset values, refusals, then random edge traffic.
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 3; k++) begin
        apb(1'b0, base[p] + 12'(k), 8'h00);
        chk("reset value", 32'h00000000, rd);
      end
    end
    apb(1'b1, 12'hF08, 8'hFF);
    chk("unmapped error", 32'h00000001, {31'h00000000, err});
    pstrb_i <= 4'h0;
    apb(1'b1, base[0] + 12'h002, 8'hFF);
    pstrb_i <= 4'hF;
    apb(1'b0, base[0] + 12'h002, 8'h00);
    chk("strobe-off write", 32'h00000000, rd);
    for (int it = 0; it < 40; it++) begin
      {low_voltage_program_enable, mclr} <= (it % 4 == 3) ? 2'($random(seed)) : 2'b00;
      ien = 1'($random(seed));
      for (int p = 0; p < 4; p++) {rise[p], fall[p], prev[p], cur[p]} = 32'($random(seed));
      level <= {prev[0], prev[1], prev[2], prev[3][3]};
      for (int p = 0; p < 4; p++) begin
        m = (p == 3) ? pin_change_pkg::E_PIN_MASK : 8'hFF;
        apb(1'b1, base[p] + 12'h002, rise[p]);
        apb(1'b1, base[p] + 12'h001, fall[p]);
        apb(1'b0, base[p] + 12'h002, 8'h00);
        chk("rise enable", {24'h000000, rise[p] & m}, rd);
        apb(1'b0, base[p] + 12'h001, 8'h00);
        chk("fall enable", {24'h000000, fall[p] & m}, rd);
        flg[p] = edges(prev[p], cur[p], rise[p], fall[p]) & m;
        if (p == 3 && (mclr || low_voltage_program_enable)) flg[p] = 8'h00;
        apb(1'b1, base[p], 8'h00);
      end
      apb(1'b1, pin_change_pkg::IRQ_EN_IDX, {7'h00, ien});
      apb(1'b1, pin_change_pkg::IRQ_CLR_IDX, 8'h01);
      level <= {cur[0], cur[1], cur[2], cur[3][3]};
      repeat (4) @(posedge ref_clk_i);
      any = |{flg[0], flg[1], flg[2], flg[3]};
      @(negedge ref_clk_i);
      chk("interrupt", {31'h00000000, any & ien}, {31'h00000000, irq_o});
      for (int p = 0; p < 4; p++) begin
        apb(1'b1, base[p], 8'hFF);
        apb(1'b0, base[p], 8'h00);
        chk("change flag", {24'h000000, flg[p]}, rd);
      end
      apb(1'b0, pin_change_pkg::IRQ_STAT_IDX, 8'h00);
      chk("change status", {31'h00000000, any}, rd);
      apb(1'b1, pin_change_pkg::IRQ_CLR_IDX, 8'h01);
      apb(1'b0, pin_change_pkg::IRQ_STAT_IDX, 8'h00);
      chk("cleared status", 32'h00000000, rd);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
